// *** test_usb_out_endpoint_ctrl_status.sv ***
// Self-checking bench for the OUT endpoint control low byte.
// Assumes the uoec_host model drives the link events.
`timescale 1ns/1ps
module test_usb_out_endpoint_ctrl_status;
	import uoec_pkg::*;
	logic clk, rst_n, wr, rd;
	logic [7:0] addr, wdata;
	wire logic [7:0] rdata;
	wire logic tok, done, err, adv, stall, tog, ptr, disc, iso, irq;
	int error_cnt = 0, samples_checked = 0;
	// Clock starts unknown, first goes high at 50 ns and needs no initial value of its own
	always #50 clk = (clk === 1'b1) ? 1'b0 : 1'b1;
	uoec_host HOST (.clk_i(clk), .tok_o(tok), .done_o(done), .err_o(err), .adv_o(adv));
	uoec_top DUT (.REF_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .OUT_TOKEN_I(tok), .PKT_DONE_I(done),
		.PKT_ERR_I(err), .TOGGLE_ADV_I(adv), .STALL_HS_O(stall), .DATA_TOGGLE_O(tog),
		.FIFO_PTR_RST_O(ptr), .PKT_DISCARD_O(disc), .ISO_MODE_O(iso), .IRQ_O(irq));
	// ****************
	// Tasks
	// ****************
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input logic e, input logic g);
		chk_reg(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk); wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk); rd <= 1'b1; addr <= a;
		@(posedge clk); rd <= 1'b0;
		#1 chk_reg("rdata", e, rdata);
	endtask
	task automatic flush(input logic d);
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h11);
		@(posedge clk); #1 chk_pin("ptr", 1'b1, ptr);
		chk_pin("discard", d, disc);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Watchdog bounds the whole run
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
	// ****************
	// Tests
	// ****************
	initial begin
		// Non-blocking at time zero so the async reset edge is never missed
		rst_n <= 1'b0;
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= 8'h00;
		wdata <= 8'h00;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		rd_reg(8'h20, 8'h00);
		$display("test reset done");
		HOST.adv(); #1 chk_pin("toggle", 1'b1, tog);
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h80); #1 chk_pin("toggle", 1'b0, tog);
		rd_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		$display("test toggle done");
		wr_reg(UOEC_ADDR_IRQ_ENABLE, 8'h03);
		HOST.pkt(1'b0);
		rd_reg(UOEC_ADDR_CTRL_LO, 8'h01);
		rd_reg(UOEC_ADDR_IRQ_STATUS, 8'h01); chk_pin("irq", 1'b1, irq);
		wr_reg(UOEC_ADDR_IRQ_ENABLE, 8'h00); @(posedge clk); #1 chk_pin("irq", 1'b0, irq);
		wr_reg(UOEC_ADDR_IRQ_CLEAR, 8'h03); wr_reg(UOEC_ADDR_IRQ_ENABLE, 8'h03);
		rd_reg(UOEC_ADDR_IRQ_STATUS, 8'h00);
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h00); rd_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		$display("test packet done");
		wr_reg(UOEC_ADDR_CTRL_HI, 8'h80);
		HOST.pkt(1'b0); HOST.pkt(1'b0);
		flush(1'b1);
		rd_reg(UOEC_ADDR_CTRL_LO, 8'h01);
		flush(1'b1);
		rd_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		flush(1'b0);
		$display("test flush done");
		wr_reg(UOEC_ADDR_CTRL_HI, 8'h40); #1 chk_pin("iso", 1'b1, iso);
		HOST.pkt(1'b1); rd_reg(UOEC_ADDR_CTRL_LO, 8'h09);
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h00); rd_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		wr_reg(UOEC_ADDR_CTRL_HI, 8'h00);
		HOST.pkt(1'b1); rd_reg(UOEC_ADDR_CTRL_LO, 8'h01);
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		wr_reg(UOEC_ADDR_IRQ_CLEAR, 8'h03);
		$display("test error done");
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h20);
		HOST.token(); #1 chk_pin("stall", 1'b1, stall);
		rd_reg(UOEC_ADDR_CTRL_LO, 8'h60);
		rd_reg(UOEC_ADDR_IRQ_STATUS, 8'h02); chk_pin("irq", 1'b1, irq);
		HOST.pkt(1'b0); rd_reg(UOEC_ADDR_CTRL_LO, 8'h60);
		wr_reg(UOEC_ADDR_CTRL_LO, 8'h00);
		HOST.token(); #1 chk_pin("stall", 1'b0, stall);
		wr_reg(UOEC_ADDR_IRQ_CLEAR, 8'h03); rd_reg(UOEC_ADDR_IRQ_STATUS, 8'h00);
		chk_pin("irq", 1'b0, irq);
		$display("test stall done");
		end_of_test();
	end
endmodule // test_usb_out_endpoint_ctrl_status

// *** uoec_flag.sv ***
// Bank of sticky flags set by hardware events and cleared by software.
// Assumes set and clear are one-cycle pulses synchronous to the clock.
`timescale 1ns/1ps
module uoec_flag import uoec_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] flag_d;

	// Set wins, so an event landing on the clear cycle is kept
	assign flag_d = set_i | (q_o & ~clr_i);

	// Flag storage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= '0;
		end else begin
			q_o <= flag_d;
		end
	end

endmodule // uoec_flag

// *** uoec_host.sv ***
// Behavioural USB host and engine driving OUT events.
// Assumes the caller runs one task at a time.
`timescale 1ns/1ps
module uoec_host (
	input wire logic clk_i,
	output logic tok_o,
	output logic done_o,
	output logic err_o,
	output logic adv_o
);
	// ****************
	// Event tasks
	// ****************
	initial begin
		tok_o = 1'b0;
		done_o = 1'b0;
		err_o = 1'b1;
		adv_o = 1'b0;
	end
	// OUT token, stalled or not by the device
	task automatic token();
		@(posedge clk_i); tok_o <= 1'b1;
		@(posedge clk_i); tok_o <= 1'b0;
	endtask
	// Error qualifier is inverted after use so a stale level is never trusted
	task automatic pkt(input logic e);
		@(posedge clk_i); done_o <= 1'b1; err_o <= e;
		@(posedge clk_i); done_o <= 1'b0; err_o <= ~e;
	endtask
	task automatic adv();
		@(posedge clk_i); adv_o <= 1'b1;
		@(posedge clk_i); adv_o <= 1'b0;
	endtask
endmodule // uoec_host

// *** uoec_pkg.sv ***
// Constants, register map and shared arithmetic for the OUT endpoint control/status block.
// Assumes one clock domain and a simple strobe register port with 8-bit data.
package uoec_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] UOEC_ADDR_CTRL_LO = 8'h14;
	localparam logic [7:0] UOEC_ADDR_CTRL_HI = 8'h15;
	localparam logic [7:0] UOEC_ADDR_IRQ_STATUS = 8'h40;
	localparam logic [7:0] UOEC_ADDR_IRQ_CLEAR = 8'h41;
	localparam logic [7:0] UOEC_ADDR_IRQ_ENABLE = 8'h42;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int UOEC_LO_CLEAR_TOGGLE = 7;
	localparam int UOEC_LO_STALL_SENT = 6;
	localparam int UOEC_LO_STALL_REQUEST = 5;
	localparam int UOEC_LO_FLUSH = 4;
	localparam int UOEC_LO_RX_ERROR = 3;
	localparam int UOEC_LO_PKT_READY = 0;
	localparam int UOEC_HI_DOUBLE_BUF = 7;
	localparam int UOEC_HI_ISO = 6;
	localparam int UOEC_IRQ_PKT_READY = 0;
	localparam int UOEC_IRQ_STALL = 1;
	localparam int UOEC_IRQ_BITS = 2;

	// ************************************************************
	// Reset values and limits
	// ************************************************************
	localparam logic [7:0] UOEC_REG_RESET = 8'h00;
	localparam logic [1:0] UOEC_CNT_RESET = 2'h0;
	localparam logic [1:0] UOEC_CAP_SINGLE = 2'h1;
	localparam logic [1:0] UOEC_CAP_DOUBLE = 2'h2;

	// ************************************************************
	// Shared arithmetic
	// ************************************************************
	// Next buffered packet count; removals floor at zero before the new packet lands
	function automatic logic [1:0] uoec_next_count(input logic [1:0] cnt, input logic inc, input logic [1:0] dec);
		logic [1:0] left;
		left = (dec >= cnt) ? 2'h0 : cnt - dec;
		uoec_next_count = inc ? left + 2'h1 : left;
	endfunction

endpackage

// *** uoec_pkt_cnt.sv ***
// Count of complete OUT packets waiting in the endpoint FIFO.
// Assumes the caller only asserts inc_i when the count is below capacity.
`timescale 1ns/1ps
module uoec_pkt_cnt import uoec_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic inc_i,
	input wire logic [1:0] dec_i,
	output logic [1:0] cnt_o,
	output logic [1:0] cnt_nxt_o
);

	// Removals and a new arrival may share one cycle
	assign cnt_nxt_o = uoec_next_count(cnt_o, inc_i, dec_i);

	// Count storage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_o <= UOEC_CNT_RESET;
		end else begin
			cnt_o <= cnt_nxt_o;
		end
	end

endmodule // uoec_pkt_cnt

// *** uoec_top.sv ***
// OUT endpoint control/status low byte with its packet, stall, flush and error logic.
// Assumes the USB engine gives one-cycle event pulses synchronous to REF_CLK_I.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module uoec_top import uoec_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	input wire logic OUT_TOKEN_I,
	input wire logic PKT_DONE_I,
	input wire logic PKT_ERR_I,
	input wire logic TOGGLE_ADV_I,
	output logic STALL_HS_O,
	output logic DATA_TOGGLE_O,
	output logic FIFO_PTR_RST_O,
	output logic PKT_DISCARD_O,
	output logic ISO_MODE_O,
	output logic IRQ_O
);

	// ************************************************************
	// Register decode
	// ************************************************************
	logic wr_lo;
	logic wr_hi;
	logic wr_irq_clr;
	logic wr_irq_en;

	// Address match for each write target
	assign wr_lo = REG_WR_I && (REG_ADDR_I == UOEC_ADDR_CTRL_LO);
	assign wr_hi = REG_WR_I && (REG_ADDR_I == UOEC_ADDR_CTRL_HI);
	assign wr_irq_clr = REG_WR_I && (REG_ADDR_I == UOEC_ADDR_IRQ_CLEAR);
	assign wr_irq_en = REG_WR_I && (REG_ADDR_I == UOEC_ADDR_IRQ_ENABLE);

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic stall_request_q;
	logic stall_request_d;
	logic iso_q;
	logic iso_d;
	logic double_buf_q;
	logic double_buf_d;
	logic [UOEC_IRQ_BITS-1:0] irq_en_q;
	logic [UOEC_IRQ_BITS-1:0] irq_en_d;

	// Next values of the software-owned bits
	assign stall_request_d = wr_lo ? REG_WDATA_I[UOEC_LO_STALL_REQUEST] : stall_request_q;
	assign iso_d = wr_hi ? REG_WDATA_I[UOEC_HI_ISO] : iso_q;
	assign double_buf_d = wr_hi ? REG_WDATA_I[UOEC_HI_DOUBLE_BUF] : double_buf_q;
	assign irq_en_d = wr_irq_en ? REG_WDATA_I[UOEC_IRQ_BITS-1:0] : irq_en_q;

	// Configuration storage
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			stall_request_q <= 1'b0;
			iso_q <= 1'b0;
			double_buf_q <= 1'b0;
			irq_en_q <= '0;
		end else begin
			stall_request_q <= stall_request_d;
			iso_q <= iso_d;
			double_buf_q <= double_buf_d;
			irq_en_q <= irq_en_d;
		end
	end

	// ************************************************************
	// Packet accounting
	// ************************************************************
	logic [1:0] pkt_cnt;
	logic [1:0] pkt_cnt_nxt;
	logic [1:0] pkt_cap;
	logic pkt_ready;
	logic pkt_accept;
	logic unload;
	logic flush_q;
	logic flush_d;
	logic flush_done;
	logic [1:0] pkt_dec;
	logic ready_clear;

	// Capacity follows the double-buffer setting
	assign pkt_cap = double_buf_q ? UOEC_CAP_DOUBLE : UOEC_CAP_SINGLE;
	// Ready shows whenever a whole packet waits; a second one reappears after unload
	assign pkt_ready = (pkt_cnt != UOEC_CNT_RESET);
	// A stalled endpoint takes no data; a full FIFO drops the packet
	assign pkt_accept = PKT_DONE_I && !stall_request_q && (pkt_cnt < pkt_cap);
	// Firmware writing ready low ends the current packet
	assign unload = wr_lo && !REG_WDATA_I[UOEC_LO_PKT_READY] && pkt_ready;
	// Flush is held one cycle, then carried out, so the bit can be polled
	assign flush_d = wr_lo && REG_WDATA_I[UOEC_LO_FLUSH];
	assign flush_done = flush_q;
	// Unload and flush each take away one packet only
	assign pkt_dec = {1'b0, unload} + {1'b0, flush_done};
	assign ready_clear = unload || (flush_done && pkt_ready);

	uoec_pkt_cnt u_pkt_cnt (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.inc_i(pkt_accept),
		.dec_i(pkt_dec),
		.cnt_o(pkt_cnt),
		.cnt_nxt_o(pkt_cnt_nxt)
	);

	// ************************************************************
	// Flush, stall and toggle sequencing
	// ************************************************************
	logic stall_hs_d;
	logic toggle_d;
	logic clear_toggle;

	// Every OUT token met while stalled is answered with a stall handshake
	assign stall_hs_d = OUT_TOKEN_I && stall_request_q;
	assign clear_toggle = wr_lo && REG_WDATA_I[UOEC_LO_CLEAR_TOGGLE];
	// Clear beats a simultaneous advance so firmware always sees zero after it
	assign toggle_d = clear_toggle ? 1'b0 : (TOGGLE_ADV_I ? !DATA_TOGGLE_O : DATA_TOGGLE_O);

	// Sequencing storage; the pointer-reset pulse also goes out when the FIFO is empty, the discard pulse does not
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			flush_q <= 1'b0;
			STALL_HS_O <= 1'b0;
			DATA_TOGGLE_O <= 1'b0;
			FIFO_PTR_RST_O <= 1'b0;
			PKT_DISCARD_O <= 1'b0;
			ISO_MODE_O <= 1'b0;
		end else begin
			flush_q <= flush_d;
			STALL_HS_O <= stall_hs_d;
			DATA_TOGGLE_O <= toggle_d;
			FIFO_PTR_RST_O <= flush_done;
			PKT_DISCARD_O <= flush_done && pkt_ready;
			ISO_MODE_O <= iso_d;
		end
	end

	// ************************************************************
	// Status flags
	// ************************************************************
	logic stall_sent_q;
	logic stall_sent_clr;
	logic rx_error_q;
	logic rx_error_set;
	logic [UOEC_IRQ_BITS-1:0] irq_status_q;
	logic [UOEC_IRQ_BITS-1:0] irq_set;
	logic [UOEC_IRQ_BITS-1:0] irq_clr;
	logic ready_event;

	// Firmware clears stall-sent by writing zero to it
	assign stall_sent_clr = wr_lo && !REG_WDATA_I[UOEC_LO_STALL_SENT];
	// Errors only latch in isochronous mode, where the flag carries meaning
	assign rx_error_set = pkt_accept && PKT_ERR_I && iso_q;
	// Ready rises, or rises again after an unload or a flush with a packet still queued
	assign ready_event = (pkt_cnt_nxt != UOEC_CNT_RESET) && (!pkt_ready || (pkt_dec != 2'h0));
	assign irq_set = {stall_hs_d, ready_event};
	assign irq_clr = wr_irq_clr ? REG_WDATA_I[UOEC_IRQ_BITS-1:0] : '0;

	uoec_flag #(.W(1)) u_stall_sent (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.set_i(stall_hs_d),
		.clr_i(stall_sent_clr),
		.q_o(stall_sent_q)
	);

	uoec_flag #(.W(1)) u_rx_error (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.set_i(rx_error_set),
		.clr_i(ready_clear),
		.q_o(rx_error_q)
	);

	uoec_flag #(.W(UOEC_IRQ_BITS)) u_irq_status (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.q_o(irq_status_q)
	);

	// ************************************************************
	// Read data and interrupt
	// ************************************************************
	logic [7:0] ctrl_lo_val;
	logic [7:0] ctrl_hi_val;
	logic [7:0] rdata_d;
	logic irq_d;

	// Clear-toggle is a command and reads back zero; excluded bits read zero
	assign ctrl_lo_val = {1'b0, stall_sent_q, stall_request_q, flush_q, rx_error_q, 2'b00, pkt_ready};
	assign ctrl_hi_val = {double_buf_q, iso_q, 6'h00};
	// Unmapped addresses and the write-only clear register read zero
	assign rdata_d = !REG_RD_I ? UOEC_REG_RESET :
		(REG_ADDR_I == UOEC_ADDR_CTRL_LO) ? ctrl_lo_val :
		(REG_ADDR_I == UOEC_ADDR_CTRL_HI) ? ctrl_hi_val :
		(REG_ADDR_I == UOEC_ADDR_IRQ_STATUS) ? {6'h00, irq_status_q} :
		(REG_ADDR_I == UOEC_ADDR_IRQ_ENABLE) ? {6'h00, irq_en_q} : UOEC_REG_RESET;
	assign irq_d = |(irq_status_q & irq_en_q);

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			REG_RDATA_O <= UOEC_REG_RESET;
			IRQ_O <= 1'b0;
		end else begin
			REG_RDATA_O <= rdata_d;
			IRQ_O <= irq_d;
		end
	end

endmodule // uoec_top

// *** uoec_top_props.sv ***
// Checker for the OUT endpoint control low byte ports.
// Assumes it is bound to uoec_top and sees only its ports.
`timescale 1ns/1ps
module uoec_top_props import uoec_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_RDATA_O,
	input wire logic OUT_TOKEN_I,
	input wire logic TOGGLE_ADV_I,
	input wire logic STALL_HS_O,
	input wire logic DATA_TOGGLE_O,
	input wire logic FIFO_PTR_RST_O,
	input wire logic PKT_DISCARD_O,
	input wire logic ISO_MODE_O
);
	// ****************
	// Decode and sequences
	// ****************
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Strobe decode kept as nets so $past sees one signal
	wire logic wr_lo = REG_WR_I && REG_ADDR_I == UOEC_ADDR_CTRL_LO;
	wire logic clr_wr = wr_lo && REG_WDATA_I[UOEC_LO_CLEAR_TOGGLE];
	wire logic flush_wr = wr_lo && REG_WDATA_I[UOEC_LO_FLUSH];
	sequence s_flush_req; flush_wr; endsequence
	sequence s_flush_out; ##2 FIFO_PTR_RST_O; endsequence
	property p_clr_tog; clr_wr |=> !DATA_TOGGLE_O; endproperty
	property p_tog_cause; !$stable(DATA_TOGGLE_O) |-> $past(TOGGLE_ADV_I) || $past(clr_wr); endproperty
	property p_clr_rd; REG_RD_I && REG_ADDR_I == UOEC_ADDR_CTRL_LO |=> !REG_RDATA_O[7]; endproperty
	property p_stall_cause; STALL_HS_O |-> $past(OUT_TOKEN_I); endproperty
	property p_flush_ptr; s_flush_req |-> s_flush_out; endproperty
	property p_ptr_cause; FIFO_PTR_RST_O |-> $past(flush_wr, 2); endproperty
	property p_discard; PKT_DISCARD_O |-> FIFO_PTR_RST_O; endproperty
	property p_iso; REG_WR_I && REG_ADDR_I == UOEC_ADDR_CTRL_HI |=> ISO_MODE_O == $past(REG_WDATA_I[6]); endproperty
	a_clr_tog: assert property (p_clr_tog) else $error("toggle not cleared");
	a_tog_cause: assert property (p_tog_cause) else $error("toggle moved alone");
	a_clr_rd: assert property (p_clr_rd) else $error("clear bit read back");
	a_stall_cause: assert property (p_stall_cause) else $error("stall without token");
	a_flush_ptr: assert property (p_flush_ptr) else $error("flush gave no pointer reset");
	a_ptr_cause: assert property (p_ptr_cause) else $error("pointer reset without flush");
	a_discard: assert property (p_discard) else $error("discard without pointer reset");
	a_iso: assert property (p_iso) else $error("iso mode wrong");
endmodule // uoec_top_props

bind uoec_top uoec_top_props u_props (.*);
